// file: port_ef_defines.vh
// Register offsets, reset values and field positions of the shared port E/F block
`ifndef PORT_EF_DEFINES_VH
`define PORT_EF_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_PORT_E_DATA      8'h08
`define OFS_PORT_F_DATA      8'h09
`define OFS_PORT_E_DIR       8'h0C
`define OFS_PORT_F_DIR       8'h0D
`define OFS_PERIPH_CTRL      8'h10
`define OFS_PIN_OWNER        8'h11

// ****************************************
// Reset values
// ****************************************
`define RST_PORT_E_DIR       8'h00
`define RST_PORT_F_DIR       4'h0
`define RST_PERIPH_CTRL      8'h00

// ****************************************
// Peripheral control field positions
// ****************************************
`define PC_SPI_EN            0
`define PC_SPI_MASTER        1
`define PC_MODF_EN           2
`define PC_ASYNC_EN          3
`define PC_TA_EXT_CLK        4
`define PC_TB_EXT_CLK        5

// ****************************************
// Port pin positions
// ****************************************
`define PE_SPI_CLK           7
`define PE_SPI_MOSI          6
`define PE_SPI_MISO          5
`define PE_SPI_SS            4
`define PE_TA_CH1            3
`define PE_TA_CH0            2
`define PE_RX                1
`define PE_TX                0
`define PF_TA_CLK            3
`define PF_TB_CLK            2
`define PF_TB_CH1            1
`define PF_TB_CH0            0

`endif

// file: shared_pin_ports_e_f.v
// Shared general-purpose ports E (8 bits) and F (4 bits) with peripheral pin ownership
`timescale 1ns/1ps
`default_nettype none
`include "port_ef_defines.vh"

module shared_pin_ports_e_f #(
  parameter E_WIDTH = 8,
  parameter F_WIDTH = 4
) (
  input  wire               ref_clk,        // System bus clock, 20 MHz
  input  wire               reset,          // Synchronous reset, active high
  input  wire [7:0]         addr,           // Register address
  input  wire [7:0]         wdata,          // Write data
  input  wire               wr_stb,         // Write strobe
  input  wire               rd_stb,         // Read strobe
  output reg  [7:0]         rdata,          // Read data, one cycle after rd_stb
  input  wire [E_WIDTH-1:0] port_e_in,      // Port E pin levels
  output wire [E_WIDTH-1:0] port_e_out,     // Port E pin drive value
  output wire [E_WIDTH-1:0] port_e_oe,      // Port E pin output enable
  input  wire [F_WIDTH-1:0] port_f_in,      // Port F pin levels
  output wire [F_WIDTH-1:0] port_f_out,     // Port F pin drive value
  output wire [F_WIDTH-1:0] port_f_oe,      // Port F pin output enable
  input  wire [1:0]         ta_ch_own,      // Timer A channel 1,0 pins selected
  input  wire [1:0]         tb_ch_own,      // Timer B channel 1,0 pins selected
  input  wire [E_WIDTH-1:0] e_periph_out,   // Peripheral drive values for port E
  input  wire [E_WIDTH-1:0] e_periph_oe,    // Peripheral drive enables for port E
  input  wire [F_WIDTH-1:0] f_periph_out,   // Timer drive values for port F
  input  wire [F_WIDTH-1:0] f_periph_oe,    // Timer drive enables for port F
  output wire [E_WIDTH-1:0] e_periph_in,    // Synchronised port E levels to peripherals
  output wire [F_WIDTH-1:0] f_periph_in,    // Synchronised port F levels to timers
  output wire [E_WIDTH-1:0] e_owned,        // Port E pins held by a peripheral
  output wire [F_WIDTH-1:0] f_owned,        // Port F pins held by a timer
  output wire               spi_enable,     // Serial peripheral enable
  output wire               spi_master,     // Serial peripheral master select
  output wire               modf_enable,    // Mode-fault detect enable
  output wire               async_enable,   // Async serial enable
  output wire               ta_ext_clk_sel, // Timer A external clock chosen
  output wire               tb_ext_clk_sel  // Timer B external clock chosen
);

  // ****************************************
  // Registers
  // ****************************************
  reg [E_WIDTH-1:0] e_latch_reg;
  reg [E_WIDTH-1:0] e_dir_reg;
  reg [F_WIDTH-1:0] f_latch_reg;
  reg [F_WIDTH-1:0] f_dir_reg;
  reg [7:0]         ctrl_reg;
  reg [E_WIDTH-1:0] e_sync1_reg;
  reg [E_WIDTH-1:0] e_sync2_reg;
  reg [F_WIDTH-1:0] f_sync1_reg;
  reg [F_WIDTH-1:0] f_sync2_reg;
  reg [7:0]         rdata_next;

  // Per-bit choice of latch or pin level for a port read
  function [7:0] port_read;
    input [7:0] latch;
    input [7:0] dir;
    input [7:0] pin;
    begin
      port_read = (latch & dir) | (pin & ~dir);
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two stages before any logic reads pin levels
  always @(posedge ref_clk) begin
    e_sync1_reg <= port_e_in;
    e_sync2_reg <= e_sync1_reg;
    f_sync1_reg <= port_f_in;
    f_sync2_reg <= f_sync1_reg;
  end

  assign e_periph_in = e_sync2_reg;
  assign f_periph_in = f_sync2_reg;

  // ****************************************
  // Register writes
  // ****************************************
  // Data latches have no reset term
  always @(posedge ref_clk) begin
    if (wr_stb && addr == `OFS_PORT_E_DATA) begin
      e_latch_reg <= wdata[E_WIDTH-1:0];
    end
    if (wr_stb && addr == `OFS_PORT_F_DATA) begin
      f_latch_reg <= wdata[F_WIDTH-1:0];
    end
  end

  // Direction and control registers with reset
  always @(posedge ref_clk) begin
    if (reset) begin
      e_dir_reg <= `RST_PORT_E_DIR;
      f_dir_reg <= `RST_PORT_F_DIR;
      ctrl_reg  <= `RST_PERIPH_CTRL;
    end else if (wr_stb) begin
      if (addr == `OFS_PORT_E_DIR) begin
        e_dir_reg <= wdata[E_WIDTH-1:0];
      end else if (addr == `OFS_PORT_F_DIR) begin
        f_dir_reg <= wdata[F_WIDTH-1:0];
      end else if (addr == `OFS_PERIPH_CTRL) begin
        ctrl_reg <= wdata;
      end
    end
  end

  assign spi_enable     = ctrl_reg[`PC_SPI_EN];
  assign spi_master     = ctrl_reg[`PC_SPI_MASTER];
  assign modf_enable    = ctrl_reg[`PC_MODF_EN];
  assign async_enable   = ctrl_reg[`PC_ASYNC_EN];
  assign ta_ext_clk_sel = ctrl_reg[`PC_TA_EXT_CLK];
  assign tb_ext_clk_sel = ctrl_reg[`PC_TB_EXT_CLK];

  // ****************************************
  // Pin ownership
  // ****************************************
  wire ss_owned;
  assign ss_owned = spi_enable & ~(spi_master & ~modf_enable);

  assign e_owned[`PE_SPI_CLK]  = spi_enable;
  assign e_owned[`PE_SPI_MOSI] = spi_enable;
  assign e_owned[`PE_SPI_MISO] = spi_enable;
  assign e_owned[`PE_SPI_SS]   = ss_owned;
  assign e_owned[`PE_TA_CH1]   = ta_ch_own[1];
  assign e_owned[`PE_TA_CH0]   = ta_ch_own[0];
  assign e_owned[`PE_RX]       = async_enable;
  assign e_owned[`PE_TX]       = async_enable;

  assign f_owned[`PF_TA_CLK] = ta_ext_clk_sel;
  assign f_owned[`PF_TB_CLK] = tb_ext_clk_sel;
  assign f_owned[`PF_TB_CH1] = tb_ch_own[1];
  assign f_owned[`PF_TB_CH0] = tb_ch_own[0];

  // ****************************************
  // Pin drivers
  // ****************************************
  // Owned pins follow the peripheral, others the latch and direction
  assign port_e_out = (e_owned & e_periph_out) | (~e_owned & e_latch_reg);
  assign port_e_oe  = (e_owned & e_periph_oe) | (~e_owned & e_dir_reg);
  assign port_f_out = (f_owned & f_periph_out) | (~f_owned & f_latch_reg);
  assign port_f_oe  = (f_owned & f_periph_oe) | (~f_owned & f_dir_reg);

  // ****************************************
  // Register reads
  // ****************************************
  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_next = 8'h00;
    if (addr == `OFS_PORT_E_DATA) begin
      rdata_next = port_read(e_latch_reg, e_dir_reg, e_sync2_reg);
    end else if (addr == `OFS_PORT_F_DATA) begin
      rdata_next = port_read({4'h0, f_latch_reg}, {4'h0, f_dir_reg},
                             {4'h0, f_sync2_reg});
    end else if (addr == `OFS_PORT_E_DIR) begin
      rdata_next = e_dir_reg;
    end else if (addr == `OFS_PORT_F_DIR) begin
      rdata_next = {4'h0, f_dir_reg};
    end else if (addr == `OFS_PERIPH_CTRL) begin
      rdata_next = {2'h0, ctrl_reg[5:0]};
    end else if (addr == `OFS_PIN_OWNER) begin
      rdata_next = {e_owned[7:4], f_owned};
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // shared_pin_ports_e_f
`default_nettype wire

// file: port_ef_chk_sva.sv
// Assertions on the pins and register bus of the shared port E/F block
`timescale 1ns/1ps
`default_nettype none
module port_ef_chk #(
  parameter E_WIDTH = 8,
  parameter F_WIDTH = 4
) (
  input wire logic ref_clk, reset, wr_stb, rd_stb, // Clock, reset, strobes
  input wire logic [7:0] addr, wdata, rdata, // Register bus
  input wire logic [E_WIDTH-1:0] port_e_out, port_e_oe, e_periph_out, e_periph_oe, e_owned, // E
  input wire logic [F_WIDTH-1:0] port_f_oe, f_periph_oe, f_owned, // Port F
  input wire logic [1:0] ta_ch_own, tb_ch_own, // Timer channel selects
  input wire logic spi_enable, spi_master, modf_enable, async_enable, // Serial controls
  input wire logic ta_ext_clk_sel, tb_ext_clk_sel, // Timer clock selects
  input wire logic [E_WIDTH-1:0] port_e_in, e_periph_in, // Port E pin and synced level
  input wire logic [F_WIDTH-1:0] port_f_in, f_periph_in // Port F pin and synced level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ********
  // Ownership, pin drive, read port and pin synchronisers
  // ********
  AST_SPI_PINS: assert property (e_owned[7:5] == {3{spi_enable}})
    else $error("serial clock and data pins ownership wrong");
  AST_SS_PIN: assert property (e_owned[4] == (spi_enable && !(spi_master && !modf_enable)))
    else $error("slave select pin ownership wrong");
  AST_TA_PINS: assert property (e_owned[3:2] == ta_ch_own)
    else $error("timer A channel pins ownership wrong");
  AST_ASYNC_PINS: assert property (e_owned[1:0] == {2{async_enable}})
    else $error("async serial pins ownership wrong");
  AST_F_PINS: assert property (f_owned == {ta_ext_clk_sel, tb_ext_clk_sel, tb_ch_own})
    else $error("port F ownership wrong");
  AST_OWNED_DRIVE: assert property ((((port_e_oe ^ e_periph_oe) | (port_e_out ^ e_periph_out)) & e_owned) == 0 && ((port_f_oe ^ f_periph_oe) & f_owned) == 0)
    else $error("owned pin not driven by its peripheral");
  AST_DIR_WRITE: assert property (wr_stb && addr == 8'h0C |=> ((port_e_oe ^ $past(wdata)) & ~e_owned) == 0)
    else $error("direction write not on output enables");
  AST_LATCH_DRIVE: assert property (wr_stb && addr == 8'h08 |=> ((port_e_out ^ $past(wdata)) & port_e_oe & ~e_owned) == 0)
    else $error("latch write not on driven pins");
  AST_RESET_DIR: assert property ($fell(reset) |-> (port_e_oe & ~e_owned) == 0 && (port_f_oe & ~f_owned) == 0)
    else $error("pin driven after reset");
  AST_RDATA_IDLE: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_F_DIR_UPPER: assert property (rd_stb && addr == 8'h0D |=> rdata[7:4] == 4'h0)
    else $error("port F direction upper bits not zero");
  AST_PIN_SYNC: assert property (!$past(reset, 2) |-> e_periph_in == $past(port_e_in, 2) && f_periph_in == $past(port_f_in, 2))
    else $error("synchronised pin levels not two cycles behind pins");
endmodule // port_ef_chk
bind shared_pin_ports_e_f port_ef_chk #(.E_WIDTH(E_WIDTH), .F_WIDTH(F_WIDTH)) u_chk (.ref_clk,
  .reset, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .port_e_out, .port_e_oe, .e_periph_out,
  .e_periph_oe, .e_owned, .port_f_oe, .f_periph_oe, .f_owned, .ta_ch_own, .tb_ch_own, .spi_enable,
  .spi_master, .modf_enable, .async_enable, .ta_ext_clk_sel, .tb_ext_clk_sel, .port_e_in,
  .e_periph_in, .port_f_in, .f_periph_in);
`default_nettype wire

// file: pin_side.sv
// Package pins of ports E and F with outside drivers
`timescale 1ns/1ps
`default_nettype none
module pin_side (
  input wire logic [7:0] e_out, e_oe, e_ext, // Port E drive, enable, outside level
  input wire logic [3:0] f_out, f_oe, f_ext, // Port F drive, enable, outside level
  output logic     [7:0] e_pin,              // Port E wire level
  output logic     [3:0] f_pin               // Port F wire level
);
  // An enabled buffer wins; an undriven pin shows the outside level
  assign e_pin = (e_oe & e_out) | (~e_oe & e_ext);
  assign f_pin = (f_oe & f_out) | (~f_oe & f_ext);
endmodule // pin_side
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the shared port E/F block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("Error %0t got %h expected %h", $time, a, b); end end
module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, rd_seen = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, got_exp, lat_e, dir_e, ext_e = 8'h00, pe_out = 8'h00, pe_oe = 8'h00;
  logic [5:0] ctl = 6'h00;
  logic [3:0] lat_f, dir_f, ext_f = 4'h0, pf_out = 4'h0, pf_oe = 4'h0;
  logic [1:0] ta = 2'b00, tb = 2'b00;
  logic [7:0] exp_q[$];
  int failures = 0, comparisons = 0;
  wire logic [7:0] rdata, e_pin, e_oe, e_out;
  wire logic [3:0] f_pin, f_oe, f_out;
  wire logic [7:0] own_e = {{3{ctl[0]}}, ctl[0] & ~(ctl[1] & ~ctl[2]), ta, {2{ctl[3]}}};
  wire logic [3:0] own_f = {ctl[4], ctl[5], tb};
  shared_pin_ports_e_f u_dut (.ref_clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .port_e_in(e_pin), .port_e_out(e_out), .port_e_oe(e_oe), .port_f_in(f_pin), .port_f_out(f_out),
    .port_f_oe(f_oe), .ta_ch_own(ta), .tb_ch_own(tb), .e_periph_out(pe_out), .e_periph_oe(pe_oe),
    .f_periph_out(pf_out), .f_periph_oe(pf_oe), .e_periph_in(), .f_periph_in(), .e_owned(),
    .f_owned(), .spi_enable(), .spi_master(), .modf_enable(), .async_enable(),
    .ta_ext_clk_sel(), .tb_ext_clk_sel());
  pin_side u_pins (.e_out, .e_oe, .e_ext(ext_e), .f_out, .f_oe, .f_ext(ext_f), .e_pin, .f_pin);
  always #25 ref_clk = ~ref_clk;
  // Expected port read: latch where output, resolved pin level where input
  function automatic logic [7:0] seen(input logic [7:0] own, po, poe, lat, dir, ext);
    logic [7:0] oe;
    oe = (own & poe) | (~own & dir);
    return (lat & dir) | (((oe & ((own & po) | (~own & lat))) | (~oe & ext)) & ~dir);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {wr_stb, addr, wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    {rd_stb, addr} <= {1'b1, a};
    @(posedge ref_clk);
    rd_stb <= 1'b0;
  endtask
  task automatic finish_test;
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Monitor: read data stands in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      got_exp = exp_q.pop_front();
      `CHK(rdata, got_exp)
    end
    rd_seen = rd_stb;
  end
  // Watchdog
  initial begin
    #(5000 * 50);
    failures++;
    finish_test();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(8108));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h00);
    for (int i = 0; i < 12; i++) begin
      {ctl, lat_e, dir_e, lat_f, dir_f} = 30'($urandom);
      @(posedge ref_clk);
      {ext_e, ext_f, ta, tb, pf_out, pf_oe} <= 24'($urandom);
      {pe_out, pe_oe} <= 16'($urandom);
      wr(8'h10, {2'b00, ctl});
      wr(8'h08, lat_e);
      wr(8'h09, {4'hF, lat_f});
      if (i == 5) begin
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        ctl = 6'h00;
      end
      wr(8'h0C, dir_e);
      wr(8'h0D, {4'hA, dir_f});
      repeat (4) @(posedge ref_clk);
      rd(8'h08, seen(own_e, pe_out, pe_oe, lat_e, dir_e, ext_e));
      rd(8'h09, seen({4'h0, own_f}, {4'h0, pf_out}, {4'h0, pf_oe}, {4'h0, lat_f}, {4'h0, dir_f}, {4'h0, ext_f}));
      rd(8'h0D, {4'h0, dir_f});
      rd(8'h11, {own_e[7:4], own_f});
      rd(8'h3C, 8'h00);
      wr(8'h0C, 8'hFF);
      wr(8'h0D, 8'h0F);
      rd(8'h08, lat_e);
      rd(8'h09, {4'h0, lat_f});
    end
    repeat (3) @(posedge ref_clk);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
